// ===== rtl/reply_builder_map.vh
// Functional notes
// - read reply carries read bytes from offset 0
// - write address and count are byte aligned
// - write byte count taken from header length
// - zero reserved field only with written count
// - written count at offset 2 when capability set
// - write reply length 4 with count, else 0
// - pending reply carries the command's transaction tag
// - pending replies may repeat for one command
// - pending payload: zero reserved, timeout in ms
// - reply header copies the command's transaction tag
// - nonexistent address answered invalid-address status
`ifndef REPLY_BUILDER_MAP_VH
`define REPLY_BUILDER_MAP_VH
`define ID_READ_REQ 16'h0800
`define ID_READ_REPLY 16'h0801
`define ID_WRITE_REQ 16'h0802
`define ID_WRITE_REPLY 16'h0803
`define ID_PENDING_REPLY 16'h0805
`define ST_SUCCESS 16'h0000
`define ST_NOT_IMPL 16'h8001
`define ST_INVALID_PARAM 16'h8002
`define ST_INVALID_ADDR 16'h8003
`define WR_ADDR_BYTES 16'h0008
`define WR_REPLY_LEN_FULL 16'h0004
`define WR_REPLY_LEN_NONE 16'h0000
`define CLK_MHZ 200
`define PENDING_MARGIN_US 100
`define MS_CYCLES (`CLK_MHZ * 1000)
`endif

// ===== rtl/memory_access_reply_builder.v
`timescale 1ns/1ps
`include "reply_builder_map.vh"
module memory_access_reply_builder #(
    parameter MS_CYCLES = `MS_CYCLES,
    parameter MARGIN_CYCLES = `PENDING_MARGIN_US * `CLK_MHZ
) (
    // clock and reset
    input wire i_clk,
    input wire i_nrst,
    // capability and timing settings
    input wire i_cap_len_written,
    input wire [15:0] i_max_response_time_setting,
    input wire [15:0] i_pending_timeout_ms,
    // parsed command: common header and command payload fields
    input wire i_cmd_valid,
    output wire o_cmd_ready,
    input wire [15:0] i_cmd_id,
    input wire [15:0] i_cmd_length,
    input wire [15:0] i_transaction_tag,
    input wire [63:0] i_cmd_addr,
    input wire [15:0] i_read_length,
    // register access port, byte wide
    output reg o_mem_req,
    output reg o_mem_we,
    output reg [63:0] o_mem_addr,
    output reg [7:0] o_mem_wdata,
    input wire i_mem_done,
    input wire i_mem_err,
    input wire [7:0] i_mem_rdata,
    // write data bytes following the address field
    input wire i_wdata_valid,
    output wire o_wdata_ready,
    input wire [7:0] i_wdata,
    // reply header and payload byte stream
    output reg o_hdr_valid,
    input wire i_hdr_ready,
    output reg [15:0] o_reply_status,
    output reg [15:0] o_reply_id,
    output reg [15:0] o_reply_length,
    output reg [15:0] o_reply_tag,
    output reg o_pay_valid,
    input wire i_pay_ready,
    output reg [7:0] o_pay_data,
    output reg o_pay_last
);
    localparam S_IDLE = 3'd0;
    localparam S_ACCESS = 3'd1;
    localparam S_WAIT = 3'd2;
    localparam S_PAY = 3'd3;
    localparam S_HDR = 3'd4;
    localparam S_WRPAY = 3'd5;
    localparam S_PEND = 3'd6;
    localparam S_PENDPAY = 3'd7;

    reg [2:0] state_r;
    reg is_write_r;
    reg [15:0] total_r;
    reg [15:0] done_r;
    reg [15:0] status_r;
    reg [15:0] tag_r;
    reg [1:0] bidx_r;
    reg [31:0] tmo_r;
    reg [15:0] pend_ms_r;
    reg [31:0] limit_r;
    // access answer that arrived while a pending reply was going out
    reg seen_r;
    reg seen_err_r;
    reg [7:0] seen_byte_r;

    assign o_cmd_ready = (state_r == S_IDLE);
    assign o_wdata_ready = (state_r == S_ACCESS) && is_write_r && !o_mem_req;

    // payload byte of a four byte reply: zero pair then 16-bit value, msb first
    function [7:0] pay_byte;
        input [1:0] idx;
        input [15:0] val;
        begin
            case (idx)
                2'd2: pay_byte = val[15:8];
                2'd3: pay_byte = val[7:0];
                default: pay_byte = 8'h00;
            endcase
        end
    endfunction

    // command sequencer
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            state_r <= S_IDLE;
            is_write_r <= 1'b0;
            total_r <= 16'h0000;
            done_r <= 16'h0000;
            status_r <= 16'h0000;
            tag_r <= 16'h0000;
            bidx_r <= 2'd0;
            tmo_r <= 32'h0000_0000;
            pend_ms_r <= 16'h0000;
            limit_r <= 32'h0000_0000;
            seen_r <= 1'b0;
            seen_err_r <= 1'b0;
            seen_byte_r <= 8'h00;
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= 64'h0;
            o_mem_wdata <= 8'h00;
            o_hdr_valid <= 1'b0;
            o_reply_status <= 16'h0000;
            o_reply_id <= 16'h0000;
            o_reply_length <= 16'h0000;
            o_reply_tag <= 16'h0000;
            o_pay_valid <= 1'b0;
            o_pay_data <= 8'h00;
            o_pay_last <= 1'b0;
        end else begin
            // response time watch, restarted by each pending reply
            if (state_r != S_IDLE)
                tmo_r <= tmo_r + 32'd1;
            // keep a slow access answer that lands during a pending reply
            if (o_mem_req && i_mem_done && (state_r == S_PEND || state_r == S_PENDPAY)) begin
                o_mem_req <= 1'b0;
                seen_r <= 1'b1;
                seen_err_r <= i_mem_err;
                seen_byte_r <= i_mem_rdata;
            end
            case (state_r)
                S_IDLE: begin
                    if (i_cmd_valid) begin
                        tag_r <= i_transaction_tag;
                        o_mem_addr <= i_cmd_addr;
                        done_r <= 16'h0000;
                        status_r <= `ST_SUCCESS;
                        tmo_r <= 32'h0000_0000;
                        limit_r <= i_max_response_time_setting * MS_CYCLES - MARGIN_CYCLES;
                        if (i_cmd_id == `ID_WRITE_REQ) begin
                            is_write_r <= 1'b1;
                            // stored bytes = header length minus address field
                            if (i_cmd_length < `WR_ADDR_BYTES) begin
                                total_r <= 16'h0000;
                                status_r <= `ST_INVALID_PARAM;
                            end else
                                total_r <= i_cmd_length - `WR_ADDR_BYTES;
                            state_r <= S_ACCESS;
                        end else if (i_cmd_id == `ID_READ_REQ) begin
                            is_write_r <= 1'b0;
                            total_r <= i_read_length;
                            state_r <= S_ACCESS;
                        end else begin
                            is_write_r <= 1'b0;
                            total_r <= 16'h0000;
                            status_r <= `ST_NOT_IMPL;
                            state_r <= S_HDR;
                        end
                    end
                end
                S_ACCESS: begin
                    if (tmo_r >= limit_r) begin
                        state_r <= S_PEND;
                    end else if (done_r == total_r || status_r != `ST_SUCCESS) begin
                        state_r <= S_HDR;
                    end else if (!is_write_r) begin
                        o_mem_req <= 1'b1;
                        o_mem_we <= 1'b0;
                        state_r <= S_WAIT;
                    end else if (i_wdata_valid) begin
                        // one byte per access, any byte address
                        o_mem_req <= 1'b1;
                        o_mem_we <= 1'b1;
                        o_mem_wdata <= i_wdata;
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (i_mem_done || seen_r) begin
                        o_mem_req <= 1'b0;
                        seen_r <= 1'b0;
                        if (i_mem_done ? i_mem_err : seen_err_r) begin
                            status_r <= `ST_INVALID_ADDR;
                            state_r <= S_HDR;
                        end else if (is_write_r) begin
                            done_r <= done_r + 16'd1;
                            o_mem_addr <= o_mem_addr + 64'd1;
                            state_r <= S_ACCESS;
                        end else begin
                            // read byte goes straight out at payload offset done_r
                            o_pay_valid <= 1'b1;
                            o_pay_data <= i_mem_done ? i_mem_rdata : seen_byte_r;
                            o_pay_last <= (done_r + 16'd1 == total_r);
                            state_r <= S_PAY;
                        end
                    end else if (tmo_r >= limit_r) begin
                        // slow access: pending reply while the request stands
                        state_r <= S_PEND;
                    end
                end
                S_PAY: begin
                    if (i_pay_ready) begin
                        o_pay_valid <= 1'b0;
                        done_r <= done_r + 16'd1;
                        o_mem_addr <= o_mem_addr + 64'd1;
                        state_r <= S_ACCESS;
                    end
                end
                S_HDR: begin
                    if (!o_hdr_valid) begin
                        o_hdr_valid <= 1'b1;
                        o_reply_status <= status_r;
                        o_reply_tag <= tag_r;
                        if (is_write_r) begin
                            o_reply_id <= `ID_WRITE_REPLY;
                            o_reply_length <= i_cap_len_written ?
                                `WR_REPLY_LEN_FULL : `WR_REPLY_LEN_NONE;
                        end else begin
                            o_reply_id <= (status_r == `ST_NOT_IMPL) ?
                                `ID_READ_REPLY | 16'h0000 : `ID_READ_REPLY;
                            o_reply_length <= status_r == `ST_NOT_IMPL ? 16'h0000 : done_r;
                        end
                    end else if (i_hdr_ready) begin
                        o_hdr_valid <= 1'b0;
                        bidx_r <= 2'd0;
                        if (is_write_r && i_cap_len_written) begin
                            o_pay_valid <= 1'b1;
                            o_pay_data <= 8'h00;
                            o_pay_last <= 1'b0;
                            state_r <= S_WRPAY;
                        end else
                            state_r <= S_IDLE;
                    end
                end
                S_WRPAY: begin
                    // zero pair, stored count at offset 2
                    if (i_pay_ready) begin
                        bidx_r <= bidx_r + 2'd1;
                        o_pay_data <= pay_byte(bidx_r + 2'd1, done_r);
                        o_pay_last <= (bidx_r == 2'd2);
                        if (bidx_r == 2'd3) begin
                            o_pay_valid <= 1'b0;
                            state_r <= S_IDLE;
                        end
                    end
                end
                S_PEND: begin
                    if (!o_hdr_valid) begin
                        o_hdr_valid <= 1'b1;
                        o_reply_status <= `ST_SUCCESS;
                        o_reply_id <= `ID_PENDING_REPLY;
                        o_reply_length <= `WR_REPLY_LEN_FULL;
                        o_reply_tag <= tag_r;
                        pend_ms_r <= i_pending_timeout_ms;
                    end else if (i_hdr_ready) begin
                        o_hdr_valid <= 1'b0;
                        bidx_r <= 2'd0;
                        o_pay_valid <= 1'b1;
                        o_pay_data <= 8'h00;
                        o_pay_last <= 1'b0;
                        state_r <= S_PENDPAY;
                    end
                end
                S_PENDPAY: begin
                    // zero pair then timeout in ms
                    if (i_pay_ready) begin
                        bidx_r <= bidx_r + 2'd1;
                        o_pay_data <= pay_byte(bidx_r + 2'd1, pend_ms_r);
                        o_pay_last <= (bidx_r == 2'd2);
                        if (bidx_r == 2'd3) begin
                            o_pay_valid <= 1'b0;
                            // next pending reply after the new window
                            tmo_r <= 32'h0000_0000;
                            limit_r <= pend_ms_r * MS_CYCLES - MARGIN_CYCLES;
                            state_r <= (o_mem_req || seen_r) ? S_WAIT : S_ACCESS;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // memory_access_reply_builder

// ===== tb/reply_builder_asserts.sv
`timescale 1ns/1ps
`include "reply_builder_map.vh"
module reply_builder_asserts (
    input wire i_clk, input wire i_nrst, input wire i_cap_len_written,
    input wire i_cmd_valid, input wire o_cmd_ready, input wire [15:0] i_transaction_tag,
    input wire o_mem_req, input wire [63:0] o_mem_addr, input wire i_mem_done,
    input wire i_mem_err, input wire o_hdr_valid, input wire i_hdr_ready,
    input wire [15:0] o_reply_status, input wire [15:0] o_reply_id,
    input wire [15:0] o_reply_length, input wire [15:0] o_reply_tag,
    input wire o_pay_valid, input wire i_pay_ready, input wire [7:0] o_pay_data
);
    reg [15:0] tag_r = 16'h0;
    wire hdr_w = o_hdr_valid && o_reply_id == `ID_WRITE_REPLY;
    wire hdr_p = o_hdr_valid && o_reply_id == `ID_PENDING_REPLY;
    // tag of the command being served
    always @(posedge i_clk) begin
        if (i_cmd_valid && o_cmd_ready) tag_r <= i_transaction_tag;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_wr_len_cap: assert property (hdr_w && o_reply_status != `ST_INVALID_PARAM
        |-> o_reply_length == (i_cap_len_written ? 16'h0004 : 16'h0000))
        else $error("write reply length wrong");
    a_pend_fields: assert property (hdr_p |-> o_reply_length == 16'h0004)
        else $error("pending length wrong");
    a_tag_copy: assert property (o_hdr_valid |-> o_reply_tag == tag_r)
        else $error("reply tag differs from command");
    a_hdr_hold: assert property (o_hdr_valid && !i_hdr_ready
        |=> o_hdr_valid && $stable(o_reply_tag) && $stable(o_reply_status))
        else $error("header changed while stalled");
    a_pay_hold: assert property (o_pay_valid && !i_pay_ready |=> o_pay_valid && $stable(o_pay_data))
        else $error("payload changed while stalled");
    a_mem_hold: assert property (o_mem_req && !i_mem_done |=> o_mem_req && $stable(o_mem_addr))
        else $error("access changed before done");
    a_err_status: assert property (o_mem_req && i_mem_done && i_mem_err
        |-> ##[1:8] o_hdr_valid && o_reply_status == `ST_INVALID_ADDR)
        else $error("missing invalid address status");
    a_one_cmd: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready)
        else $error("second command taken while busy");
    c_write: cover property (hdr_w && i_cap_len_written);
    c_pend: cover property (hdr_p && i_hdr_ready);
    c_err: cover property (o_hdr_valid && o_reply_status == `ST_INVALID_ADDR);
endmodule // reply_builder_asserts
bind memory_access_reply_builder reply_builder_asserts u_chk (.*);

// ===== tb/host_reply_sink.sv
`timescale 1ns/1ps
`include "reply_builder_map.vh"
module host_reply_sink (
    input wire i_clk,
    input wire i_clr,
    input wire i_slow,
    input wire i_hdr_valid,
    input wire [63:0] i_hdr,
    input wire i_pay_valid,
    input wire [7:0] i_pay_data,
    output wire o_hdr_ready,
    output wire o_pay_ready
);
    reg phase_r = 1'b0;
    time tmo_start_r = 0;
    logic [63:0] hq[$];
    logic [7:0] pq[$];
    // ready drops every other cycle in slow mode
    always @(posedge i_clk) phase_r <= ~phase_r;
    assign o_hdr_ready = !i_slow || phase_r;
    assign o_pay_ready = !i_slow || phase_r;
    // log accepted headers and bytes; a pending reply restarts the timer
    always @(posedge i_clk) begin
        if (i_clr) begin
            hq.delete();
            pq.delete();
        end else begin
            if (i_hdr_valid && o_hdr_ready) hq.push_back(i_hdr);
            if (i_hdr_valid && o_hdr_ready && i_hdr[47:32] == `ID_PENDING_REPLY)
                tmo_start_r = $time;
            if (i_pay_valid && o_pay_ready) pq.push_back(i_pay_data);
        end
    end
endmodule // host_reply_sink

// ===== tb/memory_access_reply_builder_tb.sv
`timescale 1ns/1ps
`include "reply_builder_map.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module memory_access_reply_builder_tb;
    reg i_clk = 1'b0, i_nrst = 1'b0, i_cap_len_written = 1'b0, i_cmd_valid = 1'b0;
    reg i_mem_done = 1'b0, i_mem_err = 1'b0, i_wdata_valid = 1'b0, clr = 1'b0, slow = 1'b0;
    reg [15:0] i_cmd_id = 16'h0, i_cmd_length = 16'h0, i_transaction_tag = 16'h0;
    reg [15:0] i_read_length = 16'h0, i_pending_timeout_ms = 16'h3;
    reg [63:0] i_cmd_addr = 64'h0;
    reg [7:0] i_mem_rdata = 8'h0, i_wdata = 8'h0;
    reg [7:0] stored[0:255];
    wire o_cmd_ready, o_mem_req, o_mem_we, o_wdata_ready, o_hdr_valid, i_hdr_ready;
    wire o_pay_valid, i_pay_ready, o_pay_last;
    wire [7:0] o_mem_wdata, o_pay_data;
    wire [15:0] o_reply_status, o_reply_id, o_reply_length, o_reply_tag;
    wire [63:0] o_mem_addr;
    integer fail_count = 0, comparisons = 0, mem_wait = 1, mem_cnt = 0;
    logic [7:0] wq[$];
    always #2.5 i_clk = ~i_clk;
    memory_access_reply_builder #(.MS_CYCLES(50), .MARGIN_CYCLES(5)) dut (
        .*, .i_max_response_time_setting(16'h0001));
    host_reply_sink host (.i_clk(i_clk), .i_clr(clr), .i_slow(slow), .i_hdr_valid(o_hdr_valid),
        .i_hdr({o_reply_status, o_reply_id, o_reply_length, o_reply_tag}),
        .i_pay_valid(o_pay_valid), .i_pay_data(o_pay_data), .o_hdr_ready(i_hdr_ready),
        .o_pay_ready(i_pay_ready));
    // register map: answers after mem_wait cycles, page ee does not exist
    always @(posedge i_clk) begin
        i_mem_done <= 1'b0;
        i_mem_err <= 1'b0;
        i_mem_rdata <= ~i_mem_rdata;
        if (o_mem_req && !i_mem_done && ++mem_cnt >= mem_wait) begin
            mem_cnt = 0;
            i_mem_done <= 1'b1;
            i_mem_err <= o_mem_addr[15:8] == 8'hee;
            i_mem_rdata <= o_mem_addr[7:0] + 8'h01;
            if (o_mem_we && o_mem_addr[15:8] != 8'hee) stored[o_mem_addr[7:0]] <= o_mem_wdata;
        end
    end
    // write data bytes after the address field
    always @(posedge i_clk) begin
        if (i_wdata_valid && o_wdata_ready) void'(wq.pop_front());
        i_wdata_valid <= wq.size() > 0;
        i_wdata <= wq.size() > 0 ? wq[0] : ~i_wdata;
    end
    task print_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input [15:0] id, l, t, input [63:0] a, input [15:0] rl);
        @(posedge i_clk);
        clr <= 1'b1;
        i_cmd_valid <= 1'b1;
        i_cmd_id <= id;
        i_cmd_length <= l;
        i_transaction_tag <= t;
        i_cmd_addr <= a;
        i_read_length <= rl;
        #1;
        while (o_cmd_ready !== 1'b1) begin @(posedge i_clk); #1; end
        @(posedge i_clk);
        clr <= 1'b0;
        i_cmd_valid <= 1'b0;
    endtask
    task automatic wait_rep(input integer n, lim, input idle);
        integer k;
        k = 0;
        #1;
        while (!(host.hq.size() >= n && (!idle || (o_cmd_ready === 1'b1 && o_pay_valid === 1'b0)))
            && k < lim) begin @(posedge i_clk); #1; k++; end
        if (k >= lim) begin fail_count++; $display("[ERR] reply exp %0d got none", n); print_verdict; end
    endtask
    task automatic t_read(input [15:0] a, rl, got, st);
        integer i;
        cmd(`ID_READ_REQ, 16'hc, a, {48'h0, a}, rl);
        wait_rep(1, 300, 1);
        for (i = 0; i < got; i++) `CHK("rd byte", a[7:0] + 8'h01 + i[7:0], host.pq[i])
        `CHK("rd hdr", {st, `ID_READ_REPLY, got, a}, host.hq[0])
    endtask
    task automatic t_write(input c, input [15:0] a, n, l, st, cnt);
        integer i;
        @(posedge i_clk);
        i_cap_len_written <= c;
        for (i = 0; i < n; i++) wq.push_back(8'ha0 + i[7:0]);
        cmd(`ID_WRITE_REQ, l, a, {48'h0, a}, 16'h5);
        wait_rep(1, 300, 1);
        for (i = 0; i < cnt; i++) `CHK("stored", 8'ha0 + i[7:0], stored[a[7:0] + i])
        `CHK("wr hdr", {st, `ID_WRITE_REPLY, c ? 16'h4 : 16'h0, a}, host.hq[0])
        `CHK("wr pay n", c ? 4 : 0, host.pq.size())
        if (c) `CHK("wr pay", {16'h0, cnt}, {host.pq[0], host.pq[1], host.pq[2], host.pq[3]})
    endtask
    task automatic t_pend;
        slow <= 1'b1;
        mem_wait = 100;
        cmd(`ID_READ_REQ, 16'hc, 16'h77, 64'h7, 16'h1);
        wait_rep(1, 50, 0);
        wait_rep(2, 600, 1);
        `CHK("pend hdr", {16'h0, `ID_PENDING_REPLY, 16'h4, 16'h77}, host.hq[0])
        `CHK("pend pay", 32'h3, {host.pq[0], host.pq[1], host.pq[2], host.pq[3]})
        `CHK("pend rd", {16'h0, `ID_READ_REPLY, 16'h1, 16'h77, 8'h08}, {host.hq[1], host.pq[4]})
        slow <= 1'b0;
        mem_wait = 1;
    endtask
    task automatic t_unknown;
        cmd(16'h0c00, 16'h0, 16'h55, 64'h0, 16'h0);
        wait_rep(1, 100, 1);
        `CHK("unk hdr", {`ST_NOT_IMPL, 32'h55}, {host.hq[0][63:48], host.hq[0][31:0]})
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_read(16'h0010, 16'h3, 16'h3, `ST_SUCCESS);
        t_read(16'hedfe, 16'h3, 16'h2, `ST_INVALID_ADDR);
        t_write(1'b1, 16'h0040, 16'h2, 16'ha, `ST_SUCCESS, 16'h2);
        t_write(1'b0, 16'h0050, 16'h3, 16'hb, `ST_SUCCESS, 16'h3);
        t_write(1'b1, 16'hee00, 16'h1, 16'h9, `ST_INVALID_ADDR, 16'h0);
        t_write(1'b0, 16'h0060, 16'h0, 16'h4, `ST_INVALID_PARAM, 16'h0);
        t_pend;
        t_unknown;
        print_verdict;
    end
endmodule // memory_access_reply_builder_tb
